// ===== pkg/nfc_pkg.sv
// package for the nand flash host sequencer: commands, timing, states
// assumes a 40 MHz system clock
`default_nettype none
package nfc_pkg;
    localparam int unsigned CLK_MHZ          = 40;
    localparam int unsigned CLK_NS           = 25;
    // commands
    localparam logic [7:0] CMD_READ_1        = 8'h00;
    localparam logic [7:0] CMD_READ_2        = 8'h30;
    localparam logic [7:0] CMD_CACHE_RD      = 8'h31;
    localparam logic [7:0] CMD_CACHE_RD_END  = 8'h3f;
    localparam logic [7:0] CMD_DATA_IN       = 8'h80;
    localparam logic [7:0] CMD_PROG          = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG    = 8'h15;
    localparam logic [7:0] CMD_STATUS        = 8'h70;
    localparam logic [7:0] CMD_RESET         = 8'hff;
    localparam int unsigned STATUS_RDY_BIT   = 6;
    // address and page limits
    localparam int unsigned ADDR_BYTES       = 5;
    localparam logic [11:0] COL_LAST         = 12'h87f;
    localparam int unsigned PARTIAL_MAX      = 4;
    // strobe timing in ns and derived cycles (least times rounded up)
    localparam int unsigned T_WP_NS          = 12;
    localparam int unsigned T_WH_NS          = 10;
    localparam int unsigned T_WHR_NS         = 60;
    localparam int unsigned T_WB_NS          = 100;
    localparam int unsigned T_RHOH_NS        = 25;
    localparam int unsigned T_RP_NS          = 12;
    localparam int unsigned T_REH_NS         = 10;
    localparam int unsigned WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WH_CYC   = (T_WH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WHR_CYC  = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WB_CYC   = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RHOH_CYC = (T_RHOH_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned REH_CYC  = (T_REH_NS + CLK_NS - 1) / CLK_NS;
    // busy limits in us; longest wait becomes a timeout
    localparam int unsigned T_BUSY_MAX_US    = 700;
    localparam int unsigned T_RST_ERASE_US   = 500;
    localparam int unsigned BUSY_TO_CYC      = T_BUSY_MAX_US * CLK_MHZ;
    localparam int unsigned RST_TO_CYC       = T_RST_ERASE_US * CLK_MHZ;
    // operations requested by the user
    typedef enum logic [2:0] {
        OP_READ      = 3'b000,
        OP_CACHE_RD  = 3'b001,
        OP_PROG      = 3'b010,
        OP_CACHE_PRG = 3'b011,
        OP_STATUS    = 3'b100,
        OP_RESET     = 3'b101
    } nfc_op_t;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_CMD1  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_WDATA = 4'b0011,
        ST_CMD2  = 4'b0100,
        ST_WB    = 4'b0101,
        ST_BUSY  = 4'b0110,
        ST_WHR   = 4'b0111,
        ST_RDATA = 4'b1000,
        ST_DONE  = 4'b1001
    } nfc_state_t;
endpackage
`default_nettype wire

// ===== hdl/nfc_host.sv
// host-side sequencer driving a byte-wide nand flash by its strobe pins
// assumes io and ready_busy_n come from pins; one 40 MHz clock domain
//
// Operation
// (RULE_01) read waits ready, at most 25 us; the code waits up to the 700 us busy timeout
// (RULE_02) cache read 31h/3Fh waits ready
// (RULE_03) page copy busy after 3Ah bounded
// (RULE_04) reset completion waited up to 500 us
// (RULE_05) final cache page busy up to 700 us
// (RULE_06) 11h cache busy wait under 10 us
// (RULE_07) 15h busy wait up to 700 us
// (RULE_08) page partial programs limited to four; the code counts only the page last programmed, and a reset op clears the count
// (RULE_09) data held 25 ns after read rise
// (RULE_10) extended output mode not relied upon
// (RULE_11) cached reads end with 3Fh
// (RULE_12) cache program ends 80h then 10h
// (RULE_13) after 80h-15h end poll status, reset; the code only holds busy high until the next op is done
// (RULE_14) data input columns up to 2175
// (RULE_15) never drive port while device outputs
// (RULE_16) command/address latched on write rise
// (RULE_17) address sent as five bytes
// (RULE_18) device busy shown low on ready_busy_n
// (RULE_19) each read fall gives next byte
// (RULE_20) wait ready before new commands; the code still accepts status and reset while busy
`default_nettype none
module nfc_host #(
    parameter int unsigned BUSY_TO = nfc_pkg::BUSY_TO_CYC,
    parameter int unsigned RST_TO  = nfc_pkg::RST_TO_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic [2:0]  op,
    input  wire logic        last,
    input  wire logic [39:0] addr,
    input  wire logic [11:0] len,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             done,
    output logic             timeout,
    output logic             partial_err,
    output logic             busy,
    output logic             cle,
    output logic             ale,
    output logic             ce_n,
    output logic             write_strobe_n,
    output logic             read_strobe_n,
    input  wire logic [7:0]  io_in,
    output logic [7:0]       io_out,
    output logic             io_oe,
    input  wire logic        ready_busy_n
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] io_s1_q, io_s2_q;
    logic       rb_s1_q, rb_s2_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end else begin
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
        end
    end

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    nfc_pkg::nfc_state_t st_q, st_d;
    nfc_pkg::nfc_op_t    op_q;
    logic [19:0] cnt_q;
    logic [2:0]  phase_q;
    logic [2:0]  idx_q;
    logic [11:0] len_q;
    logic [39:0] addr_q;
    logic        last_q;
    logic        polled_q;
    logic [16:0] pp_page_q;
    logic [2:0]  pp_cnt_q;

    // strobe phase timer: low time then high time, wide enough for all
    localparam logic [2:0] PH_LO = 3'(nfc_pkg::WP_CYC + 1);
    localparam logic [2:0] PH_HI = 3'(nfc_pkg::WH_CYC + 1);
    localparam logic [2:0] RD_LO = 3'(nfc_pkg::RP_CYC + 1);
    localparam logic [2:0] RD_HI = 3'(nfc_pkg::RHOH_CYC + 1);
    localparam logic [19:0] WB_N  = 20'(nfc_pkg::WB_CYC);
    localparam logic [19:0] WHR_N = 20'(nfc_pkg::WHR_CYC);

    wire ph_end    = (phase_q == PH_LO + PH_HI - 3'h1);
    // two cycles past the fall, once the byte has crossed the synchroniser
    wire rd_sample = (phase_q == RD_LO + 3'h1);
    wire rd_end    = (phase_q == RD_LO + RD_HI - 3'h1);
    wire is_prog   = (op_q == nfc_pkg::OP_PROG) ||
                     (op_q == nfc_pkg::OP_CACHE_PRG);
    wire is_read   = (op_q == nfc_pkg::OP_READ) ||
                     (op_q == nfc_pkg::OP_CACHE_RD);
    // (RULE_17) five address bytes
    wire [7:0] addr_byte = addr_q[8*idx_q +: 8];
    wire       wr_take   = (st_q == nfc_pkg::ST_WDATA) && wr_valid &&
                           (phase_q == 3'h0);
    wire [16:0] page_no  = addr_q[32:16];
    // (RULE_08) count partial programs of one page
    wire pp_over = (page_no == pp_page_q) &&
                   (pp_cnt_q == 3'(nfc_pkg::PARTIAL_MAX));

    // (RULE_11) (RULE_12) final command chosen by op and last flag
    logic [7:0] cmd1, cmd2;
    always_comb begin
        cmd1 = nfc_pkg::CMD_READ_1;
        cmd2 = nfc_pkg::CMD_READ_2;
        unique case (op_q)
            nfc_pkg::OP_READ: cmd2 = nfc_pkg::CMD_READ_2;
            nfc_pkg::OP_CACHE_RD: begin
                cmd1 = last_q ? nfc_pkg::CMD_CACHE_RD_END
                              : nfc_pkg::CMD_CACHE_RD;
                cmd2 = cmd1;
            end
            nfc_pkg::OP_PROG: begin
                cmd1 = nfc_pkg::CMD_DATA_IN;
                cmd2 = nfc_pkg::CMD_PROG;
            end
            nfc_pkg::OP_CACHE_PRG: begin
                cmd1 = nfc_pkg::CMD_DATA_IN;
                cmd2 = last_q ? nfc_pkg::CMD_PROG : nfc_pkg::CMD_CACHE_PROG;
            end
            nfc_pkg::OP_STATUS: cmd1 = nfc_pkg::CMD_STATUS;
            nfc_pkg::OP_RESET:  cmd1 = nfc_pkg::CMD_RESET;
            default: cmd1 = nfc_pkg::CMD_STATUS;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    wire one_cmd = (op_q == nfc_pkg::OP_STATUS) ||
                   (op_q == nfc_pkg::OP_RESET) ||
                   (op_q == nfc_pkg::OP_CACHE_RD);
    wire to_lim  = (op_q == nfc_pkg::OP_RESET) ?
                   (cnt_q == 20'(RST_TO)) : (cnt_q == 20'(BUSY_TO));
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            // (RULE_20) new command only while ready, except status and reset
            nfc_pkg::ST_IDLE:
                if (start && (rb_s2_q || op == nfc_pkg::OP_STATUS ||
                              op == nfc_pkg::OP_RESET))
                    st_d = nfc_pkg::ST_CMD1;
            nfc_pkg::ST_CMD1:
                if (ph_end)
                    st_d = one_cmd ? (op_q == nfc_pkg::OP_STATUS ?
                        nfc_pkg::ST_WHR : nfc_pkg::ST_WB)
                        : nfc_pkg::ST_ADDR;
            nfc_pkg::ST_ADDR:
                if (ph_end && idx_q == 3'(nfc_pkg::ADDR_BYTES - 1))
                    st_d = is_prog ? nfc_pkg::ST_WDATA : nfc_pkg::ST_CMD2;
            nfc_pkg::ST_WDATA:
                if (ph_end && len_q == 12'h000)
                    st_d = nfc_pkg::ST_CMD2;
            nfc_pkg::ST_CMD2:
                if (ph_end)
                    st_d = nfc_pkg::ST_WB;
            nfc_pkg::ST_WB:
                if (cnt_q == WB_N)
                    st_d = nfc_pkg::ST_BUSY;
            // (RULE_01) (RULE_02) (RULE_04) (RULE_07) wait for ready
            nfc_pkg::ST_BUSY:
                if (rb_s2_q || to_lim)
                    st_d = is_read ? nfc_pkg::ST_WHR : nfc_pkg::ST_DONE;
            nfc_pkg::ST_WHR:
                if (cnt_q == WHR_N)
                    st_d = nfc_pkg::ST_RDATA;
            nfc_pkg::ST_RDATA:
                if (rd_end && len_q == 12'h000)
                    st_d = nfc_pkg::ST_DONE;
            nfc_pkg::ST_DONE:
                st_d = nfc_pkg::ST_IDLE;
            default: st_d = nfc_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing registers
    // ------------------------------------------------------------
    wire strobing = (st_q == nfc_pkg::ST_CMD1) || (st_q == nfc_pkg::ST_ADDR)
                 || (st_q == nfc_pkg::ST_CMD2) || (st_q == nfc_pkg::ST_RDATA)
                 || (st_q == nfc_pkg::ST_WDATA && (phase_q != 3'h0 ||
                                                   wr_valid));
    wire ph_wrap  = (st_q == nfc_pkg::ST_RDATA) ? rd_end : ph_end;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q      <= nfc_pkg::ST_IDLE;
            op_q      <= nfc_pkg::OP_STATUS;
            cnt_q     <= 20'h00000;
            phase_q   <= 3'h0;
            idx_q     <= 3'h0;
            len_q     <= 12'h000;
            addr_q    <= 40'h0000000000;
            last_q    <= 1'b0;
            polled_q  <= 1'b0;
            pp_page_q <= 17'h00000;
            pp_cnt_q  <= 3'h0;
        end else begin
            st_q    <= st_d;
            phase_q <= (!strobing || ph_wrap || st_d != st_q) ? 3'h0
                       : phase_q + 3'h1;
            cnt_q   <= (st_d != st_q) ? 20'h00000 : cnt_q + 20'h00001;
            if (st_q == nfc_pkg::ST_IDLE && st_d == nfc_pkg::ST_CMD1) begin
                op_q   <= nfc_pkg::nfc_op_t'(op);
                addr_q <= addr;
                last_q <= last;
                // (RULE_14) clamp length to the page's last column
                len_q  <= (len > nfc_pkg::COL_LAST - addr[11:0]) ?
                          nfc_pkg::COL_LAST - addr[11:0] : len;
                idx_q  <= 3'h0;
            end
            if (st_q == nfc_pkg::ST_ADDR && ph_end)
                idx_q <= idx_q + 3'h1;
            if ((st_q == nfc_pkg::ST_WDATA && ph_end) ||
                (st_q == nfc_pkg::ST_RDATA && rd_end)) begin
                len_q <= len_q - 12'h001;
            end
            // (RULE_13) cache program left open: busy held high until the next op reaches done
            if (st_q == nfc_pkg::ST_DONE)
                polled_q <= (op_q == nfc_pkg::OP_CACHE_PRG) && !last_q;
            // blocked programs do not count
            if (st_q == nfc_pkg::ST_CMD2 && ph_end && is_prog && !pp_over) begin
                pp_page_q <= page_no;
                pp_cnt_q  <= (page_no == pp_page_q) ? pp_cnt_q + 3'h1 : 3'h1;
            end
            if (op_q == nfc_pkg::OP_RESET && st_q == nfc_pkg::ST_DONE)
                pp_cnt_q <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // pin and user outputs
    // ------------------------------------------------------------
    wire in_cmd  = (st_q == nfc_pkg::ST_CMD1) || (st_q == nfc_pkg::ST_CMD2);
    wire wr_st   = in_cmd || (st_q == nfc_pkg::ST_ADDR) ||
                   (st_q == nfc_pkg::ST_WDATA);
    wire [7:0] bus_d = (st_q == nfc_pkg::ST_CMD1) ? cmd1 :
                       (st_q == nfc_pkg::ST_CMD2) ? cmd2 :
                       (st_q == nfc_pkg::ST_ADDR) ? addr_byte : wr_data;
    // (RULE_16) write strobe rises at end of low phase
    wire we_lo   = wr_st && strobing && (phase_q < PH_LO);
    wire re_lo   = (st_q == nfc_pkg::ST_RDATA) && (phase_q < RD_LO);
    wire blocked = pp_over && is_prog;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cle            <= 1'b0;
            ale            <= 1'b0;
            ce_n           <= 1'b1;
            write_strobe_n <= 1'b1;
            read_strobe_n  <= 1'b1;
            io_out         <= 8'h00;
            io_oe          <= 1'b0;
            rd_data        <= 8'h00;
            rd_valid       <= 1'b0;
            wr_ready       <= 1'b0;
            done           <= 1'b0;
            timeout        <= 1'b0;
            partial_err    <= 1'b0;
            busy           <= 1'b0;
        end else begin
            cle            <= in_cmd;
            ale            <= (st_q == nfc_pkg::ST_ADDR);
            ce_n           <= (st_q == nfc_pkg::ST_IDLE);
            write_strobe_n <= !we_lo || blocked;
            // (RULE_19) one byte per read fall
            read_strobe_n  <= !re_lo;
            // data byte held from the cycle it is taken
            if (st_q != nfc_pkg::ST_WDATA || wr_take)
                io_out     <= bus_d;
            // (RULE_15) drive port only on write cycles
            io_oe          <= wr_st;
            // (RULE_09) take the byte the pins showed one cycle after the read fall, before the rise
            if (st_q == nfc_pkg::ST_RDATA && rd_sample)
                rd_data <= io_s2_q;
            rd_valid       <= (st_q == nfc_pkg::ST_RDATA) && rd_sample;
            wr_ready       <= wr_take;
            done           <= (st_q == nfc_pkg::ST_DONE);
            // (RULE_05) (RULE_06) busy bounded by timeout flag
            timeout        <= (st_q == nfc_pkg::ST_BUSY) && to_lim &&
                              !rb_s2_q;
            partial_err    <= (st_q == nfc_pkg::ST_CMD1) && ph_end &&
                              blocked;
            busy           <= (st_q != nfc_pkg::ST_IDLE) || polled_q;
        end
    end
endmodule // nfc_host
`default_nettype wire

// ===== tb/nfc_host_assertions.sv
// checker for nfc_host: strobe order, port direction, pulses
// assumes it is bound to nfc_host and watches its ports by name
`default_nettype none
module nfc_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic done,
    input wire logic rd_valid,
    input wire logic busy,
    input wire logic cle,
    input wire logic ale,
    input wire logic ce_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic io_oe,
    input wire logic ready_busy_n,
    input wire logic timeout,
    input wire logic partial_err
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ------------------------------
    // strobe, port and pulse checks
    // ------------------------------
    cmd_latch_a: assert property (
        $rose(write_strobe_n) |-> !ce_n && io_oe && !(cle && ale))
        else $error("write edge with port not driven");
    we_width_a: assert property (
        $fell(write_strobe_n) |=> !write_strobe_n)
        else $error("write strobe low too short");
    re_high_a: assert property (
        $rose(read_strobe_n) |=> read_strobe_n)
        else $error("read strobe high too short");
    port_dir_a: assert property (
        !read_strobe_n |-> !io_oe && write_strobe_n)
        else $error("port driven during read");
    busy_gate_a: assert property (
        $fell(write_strobe_n) && !cle |-> $past(ready_busy_n, 3))
        else $error("address or data while device busy");
    rd_after_a: assert property (
        $fell(read_strobe_n) |-> ##[1:6] rd_valid)
        else $error("read byte not delivered");
    done_pulse_a: assert property (
        done |=> !done)
        else $error("done longer than one cycle");
    idle_quiet_a: assert property (
        !busy [*2] |-> write_strobe_n && read_strobe_n && !io_oe)
        else $error("strobes active while idle");
    cover property (done);
    cover property (timeout);
    cover property (partial_err);
endmodule // nfc_chk
bind nfc_host nfc_chk u_chk (.*);
`default_nettype wire

// ===== tb/nfc_flash_model.sv
// behavioural flash device on the strobe pins
// assumes strobes from nfc_host; busy time set by the bench
`default_nettype none
module nfc_flash_model (
    input wire logic        cle,
    input wire logic        ale,
    input wire logic        ce_n,
    input wire logic        write_strobe_n,
    input wire logic        read_strobe_n,
    input wire logic [7:0]  io_in,
    output logic [7:0]      io_q,
    output logic            io_en,
    output logic            ready_busy_n,
    input wire logic [31:0] busy_ns
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  cmd = 8'h00;
    logic [7:0]  prev_cmd = 8'h00;
    logic [7:0]  adr [5];
    logic [11:0] col = 12'h000;
    int          n_addr = 0;
    int          n_wr = 0;
    int          n_cmd = 0;
    event        go_busy;
    initial io_q = 8'h00;
    initial io_en = 1'b0;
    initial ready_busy_n = 1'b1;
    always @(go_busy) begin
        ready_busy_n = 1'b0;
        #(busy_ns);
        ready_busy_n = 1'b1;
    end
    always @(posedge write_strobe_n) if (!ce_n) begin
        if (cle) begin
            prev_cmd = cmd;
            cmd = io_in;
            n_cmd++;
            if (io_in == 8'h00 || io_in == 8'h80) begin
                n_addr = 0;
                n_wr = 0;
            end
            if (io_in == 8'h31 || io_in == 8'h3f)
                col = 12'h000;
            if (io_in inside {8'h30, 8'h31, 8'h3f, 8'h10, 8'h15, 8'hff,
                              8'h3a})
                -> go_busy;
        end else if (ale) begin
            if (n_addr < 5)
                adr[n_addr] = io_in;
            n_addr++;
            col = {adr[1][3:0], adr[0]};
        end else
            n_wr++;
    end
    always @(negedge read_strobe_n) if (!ce_n) begin
        io_q = (cmd == 8'h70) ? {1'b0, ready_busy_n, 6'h00}
                              : col[7:0] ^ adr[2];
        io_en = 1'b1;
        col = col + 12'h001;
    end
    // short high time: release on latch or write edges
    always @(posedge cle or posedge ale or posedge ce_n
             or negedge write_strobe_n)
        io_en = 1'b0;
    always @(posedge read_strobe_n) begin
        #25;
        io_en = 1'b0;
        io_q = ~io_q;
    end
endmodule // nfc_flash_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for nfc_host against the flash model
// assumes nfc_pkg, nfc_host and the model are compiled first
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, reset_n, start, last, wr_valid, wr_ready;
    logic [2:0]  op;
    logic [39:0] addr;
    logic [11:0] len;
    logic [7:0]  wr_data, rd_data, io_out, dev_io, io_in;
    logic        rd_valid, done, timeout, partial_err, busy;
    logic        cle, ale, ce_n, we_n, re_n, io_oe, dev_en, rb_n;
    logic        saw_to, saw_pe;
    logic [7:0]  rdq [$];
    logic [31:0] busy_ns;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    assign io_in = io_oe ? io_out : dev_io;
    nfc_host #(.BUSY_TO(100), .RST_TO(100)) dut (
        .clk(clk), .reset_n(reset_n), .start(start), .op(op),
        .last(last), .addr(addr), .len(len), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .timeout(timeout),
        .partial_err(partial_err), .busy(busy), .cle(cle), .ale(ale),
        .ce_n(ce_n), .write_strobe_n(we_n), .read_strobe_n(re_n),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .ready_busy_n(rb_n));
    nfc_flash_model fm (
        .cle(cle), .ale(ale), .ce_n(ce_n), .write_strobe_n(we_n),
        .read_strobe_n(re_n), .io_in(io_in), .io_q(dev_io),
        .io_en(dev_en), .ready_busy_n(rb_n), .busy_ns(busy_ns));
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run_op(input logic [2:0] o, input logic l,
                          input logic [39:0] a, input logic [11:0] n);
        op = o;
        last = l;
        addr = a;
        len = n;
        rdq.delete();
        saw_to = 1'b0;
        saw_pe = 1'b0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk);
            if (rd_valid === 1'b1) rdq.push_back(rd_data);
            if (wr_ready === 1'b1) wr_data = wr_data + 8'h01;
            if (timeout === 1'b1) saw_to = 1'b1;
            if (partial_err === 1'b1) saw_pe = 1'b1;
            check(16'(io_oe && dev_en), 16'h0000);
            if (done === 1'b1) break;
        end
        check(16'(done), 16'h0001);
        repeat (2) @(negedge clk);
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_read();
        for (int j = 0; j < 2; j++) begin
            busy_ns = (j == 0) ? 32'd300 : 32'd2000;
            run_op(3'd0, 1'b0, 40'h00_0003_0010, 12'h003);
            check(16'(saw_to), 16'h0000);
            check(16'(fm.cmd), 16'h0030);
            check(16'(fm.n_addr), 16'h0005);
            check(16'(rdq.size()), 16'h0004);
            for (int i = 0; i < 4; i++)
                check(16'(rdq[i]), 16'(8'(8'h10 + i) ^ 8'h03));
        end
        busy_ns = 32'd300;
        $display("read test over");
    endtask
    task automatic t_cache_rd();
        run_op(3'd1, 1'b0, 40'h0, 12'h001);
        check(16'(fm.cmd), 16'h0031);
        check(16'(rdq.size()), 16'h0002);
        run_op(3'd1, 1'b1, 40'h0, 12'h001);
        check(16'(fm.cmd), 16'h003f);
        $display("cache read test over");
    endtask
    task automatic t_program();
        run_op(3'd2, 1'b0, 40'h00_0005_0000, 12'h003);
        check(16'(fm.prev_cmd), 16'h0080);
        check(16'(fm.n_wr), 16'h0004);
        run_op(3'd2, 1'b0, 40'h00_0006_087e, 12'h007);
        check(16'(fm.n_wr), 16'h0002);
        $display("program test over");
    endtask
    task automatic t_timeout();
        busy_ns = 32'd5000;
        run_op(3'd0, 1'b0, 40'h00_0003_0000, 12'h000);
        check(16'(saw_to), 16'h0001);
        repeat (200) @(negedge clk);
        busy_ns = 32'd300;
        run_op(3'd5, 1'b0, 40'h0, 12'h000);
        check(16'(fm.cmd), 16'h00ff);
        $display("timeout test over");
    endtask
    task automatic t_partial();
        int n;
        for (int i = 0; i < 5; i++) begin
            n = fm.n_cmd;
            run_op(3'd2, 1'b0, 40'h00_0007_0000, 12'h000);
            check(16'(saw_pe), (i == 4) ? 16'h0001 : 16'h0000);
        end
        check(16'(fm.n_cmd - n), 16'h0000);
        $display("partial test over");
    endtask
    task automatic t_cache_prg();
        run_op(3'd3, 1'b0, 40'h00_0008_0000, 12'h001);
        check(16'(fm.cmd), 16'h0015);
        check(16'(busy), 16'h0001);
        run_op(3'd3, 1'b1, 40'h00_0009_0000, 12'h001);
        check(16'(fm.prev_cmd), 16'h0080);
        check(16'(fm.cmd), 16'h0010);
        check(16'(busy), 16'h0000);
        run_op(3'd4, 1'b0, 40'h0, 12'h000);
        check(16'(rdq[0]), 16'h0040);
        $display("cache program test over");
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        reset_n = 1'b0;
        start = 1'b0;
        op = 3'd0;
        last = 1'b0;
        addr = 40'h0;
        len = 12'h000;
        wr_data = 8'h00;
        wr_valid = 1'b1;
        busy_ns = 32'd300;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_read();
        t_cache_rd();
        t_program();
        t_timeout();
        t_partial();
        t_cache_prg();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
